// ---- src/dcd_pkg.sv ----
package dcd_pkg;

    // serial word layout
    localparam int          WORD_BITS   = 24;
    localparam int          CNT_W       = 5;
    localparam logic [4:0]  CNT_FULL    = 5'h18;
    localparam logic [4:0]  CNT_OVER    = 5'h19;
    localparam int          MODE_HI     = 23;
    localparam int          MODE_LO     = 22;
    localparam int          ADDR_HI     = 21;
    localparam int          ADDR_LO     = 16;
    localparam int          VALUE_HI    = 15;
    localparam int          VALUE_LO    = 2;
    localparam int          ARG_HI      = 15;
    localparam int          ARG_LO      = 0;

    // mode bit encodings
    localparam logic [1:0]  MODE_SPECIAL = 2'h0;
    localparam logic [1:0]  MODE_GAIN    = 2'h1;
    localparam logic [1:0]  MODE_OFFSET  = 2'h2;
    localparam logic [1:0]  MODE_INPUT   = 2'h3;

    // special function codes
    localparam logic [5:0]  FN_NOP      = 6'h00;
    localparam logic [5:0]  FN_CTRL     = 6'h01;
    localparam logic [5:0]  FN_OFFSET_DAC_VALUE_0     = 6'h02;
    localparam logic [5:0]  FN_OFFSET_DAC_VALUE_1     = 6'h03;
    localparam logic [5:0]  FN_OFFSET_DAC_VALUE_2     = 6'h04;
    localparam logic [5:0]  FN_RBSEL    = 6'h05;
    localparam logic [5:0]  FN_BSEL0    = 6'h06;
    localparam logic [5:0]  FN_BSEL4    = 6'h0a;
    localparam logic [5:0]  FN_BSEL_ALL = 6'h0b;

    // control register bit positions and register reset values
    localparam int          CTRL_PD_BIT   = 0;
    localparam int          CTRL_TSD_BIT  = 1;
    localparam int          CTRL_BANK_BIT = 2;
    localparam logic [2:0]  CTRL_RST      = 3'h0;
    localparam logic [13:0] OFS_RST       = 14'h0000;
    localparam logic [7:0]  BSEL_RST      = 8'h00;
    localparam logic [13:0] CH_RST        = 14'h0000;

    // readback selection codes
    localparam logic [2:0]  RB_IN_A    = 3'h0;
    localparam logic [2:0]  RB_IN_B    = 3'h1;
    localparam logic [2:0]  RB_OFFSET  = 3'h2;
    localparam logic [2:0]  RB_GAIN    = 3'h3;
    localparam logic [2:0]  RB_SPECIAL = 3'h4;
    localparam logic [5:0]  RB_CH_BASE = 6'h08;
    localparam logic [5:0]  RB_CH_LAST = 6'h2f;
    localparam logic [5:0]  RB_CTRL    = 6'h01;
    localparam logic [5:0]  RB_OFFSET_DAC_VALUE_0    = 6'h02;
    localparam logic [5:0]  RB_OFFSET_DAC_VALUE_1    = 6'h03;
    localparam logic [5:0]  RB_OFFSET_DAC_VALUE_2    = 6'h04;
    localparam logic [5:0]  RB_BSEL0   = 6'h06;
    localparam logic [5:0]  RB_BSEL4   = 6'h0a;

    // per-channel register chosen by a data write
    typedef enum logic [2:0] {
        TGT_NONE   = 3'b000,
        TGT_IN_A   = 3'b001,
        TGT_IN_B   = 3'b010,
        TGT_OFFSET = 3'b011,
        TGT_GAIN   = 3'b100
    } dcd_target_t;

endpackage

// ---- src/dcd_decoder.sv ----
`timescale 1ns/10ps
module dcd_decoder
#(
    parameter int NUM_CH     = 40,
    parameter int NUM_GROUPS = 5,
    parameter int GROUP_CH   = 8,
    parameter int VAL_W      = 14
)
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // serial link pins
    input  wire logic                  sync_n,
    input  wire logic                  sclk,
    input  wire logic                  sdi,
    output logic                       sdo,
    output logic                       sdo_oe,
    // thermal sensor
    input  wire logic                  overtemp_in,
    // control register state
    output logic                       power_down_req,
    output logic                       thermal_shutdown_en,
    output logic                       input_bank_bit,
    output logic                       overtemp_flag,
    // offset dac values
    output logic [VAL_W-1:0]           offset_dac_value_0,
    output logic [VAL_W-1:0]           offset_dac_value_1,
    output logic [VAL_W-1:0]           offset_dac_value_2,
    // one bank-select bit per channel
    output logic [NUM_CH-1:0]          bank_select,
    // channel write event
    output logic                       wr_valid,
    output dcd_pkg::dcd_target_t       wr_target,
    output logic [NUM_CH-1:0]          wr_mask,
    output logic [VAL_W-1:0]           wr_value
);
    import dcd_pkg::*;

    logic              sync_s1_q, sync_s2_q, sync_p_q;
    logic              sclk_s1_q, sclk_s2_q, sclk_p_q;
    logic              sdi_s1_q, sdi_s2_q;
    logic              ot_s1_q, ot_s2_q;
    logic              frame_start, frame_end, sclk_fall;
    logic [CNT_W-1:0]  cnt_q;
    logic [WORD_BITS-1:0] word_q;
    logic              exec;
    logic [1:0]        mode;
    logic [5:0]        code;
    logic [15:0]       arg;
    logic              data_wr, spec_wr;
    logic [2:0]        ctrl_q;
    logic [VAL_W-1:0]  ofs_q [3];
    logic [NUM_CH-1:0] bsel_q;
    logic [VAL_W-1:0]  in_a_q [NUM_CH];
    logic [VAL_W-1:0]  in_b_q [NUM_CH];
    logic [VAL_W-1:0]  off_q  [NUM_CH];
    logic [VAL_W-1:0]  gain_q [NUM_CH];
    logic [15:0]       rb_sel_q;
    logic              rb_pend_q, rb_active_q, oe_q;
    logic [WORD_BITS-1:0] out_sr_q;
    logic [15:0]       rb_val;

    // channel mask for a six-bit address field
    function automatic logic [NUM_CH-1:0] chan_mask(input logic [5:0] a);
        logic [2:0]        up;
        logic [2:0]        lo;
        logic [NUM_CH-1:0] m;
        up = a[5:3];
        lo = a[2:0];
        m  = '0;
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
            for (int c = 0; c < GROUP_CH; c++)
            begin
                if ((up == 3'h0 && lo == 3'h0)
                    || (up == 3'h0 && int'(lo) == g + 1)
                    || (up >= 3'h1 && up <= 3'h5 && int'(up) == g + 1
                        && int'(lo) == c)
                    || (up == 3'h6 && int'(lo) == c)
                    || (up == 3'h7 && g >= 1 && int'(lo) == c))
                    m[g*GROUP_CH+c] = 1'b1;
            end
        end
        return m;
    endfunction

    // two-flop synchronisers for the link pins and the sensor
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sync_s1_q <= 1'b1;
            sync_s2_q <= 1'b1;
            sync_p_q  <= 1'b1;
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_p_q  <= 1'b0;
            sdi_s1_q  <= 1'b0;
            sdi_s2_q  <= 1'b0;
            ot_s1_q   <= 1'b0;
            ot_s2_q   <= 1'b0;
        end
        else
        begin
            sync_s1_q <= sync_n;
            sync_s2_q <= sync_s1_q;
            sync_p_q  <= sync_s2_q;
            sclk_s1_q <= sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_p_q  <= sclk_s2_q;
            sdi_s1_q  <= sdi;
            sdi_s2_q  <= sdi_s1_q;
            ot_s1_q   <= overtemp_in;
            ot_s2_q   <= ot_s1_q;
        end
    end

    // edges of the synchronised frame and clock
    assign frame_start = sync_p_q && !sync_s2_q;
    assign frame_end   = !sync_p_q && sync_s2_q;
    assign sclk_fall   = sclk_p_q && !sclk_s2_q && !sync_s2_q;

    // bit counter saturates one past a full word so overlong frames are seen
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cnt_q <= '0;
        else if (frame_start)
            cnt_q <= '0;
        else if (sclk_fall && cnt_q != CNT_OVER)
            cnt_q <= cnt_q + 5'h01;
    end

    // shift in msb first, stop after the 24th bit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            word_q <= '0;
        else if (sclk_fall && cnt_q < CNT_FULL)
            word_q <= {word_q[WORD_BITS-2:0], sdi_s2_q};
    end

    // field split of the received word
    assign exec    = frame_end && cnt_q == CNT_FULL;
    assign mode    = word_q[MODE_HI:MODE_LO];
    assign code    = word_q[ADDR_HI:ADDR_LO];
    assign arg     = word_q[ARG_HI:ARG_LO];
    assign data_wr = exec && mode != MODE_SPECIAL;
    assign spec_wr = exec && mode == MODE_SPECIAL;

    // channel write event, one cycle after the frame ends
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_valid  <= 1'b0;
            wr_target <= TGT_NONE;
            wr_mask   <= '0;
            wr_value  <= '0;
        end
        else
        begin
            wr_valid <= data_wr;
            if (data_wr)
            begin
                wr_mask  <= chan_mask(word_q[ADDR_HI:ADDR_LO]);
                wr_value <= word_q[VALUE_HI:VALUE_LO];
                unique case (mode)
                    MODE_INPUT:  wr_target <= ctrl_q[CTRL_BANK_BIT] ? TGT_IN_B
                                                                    : TGT_IN_A;
                    MODE_OFFSET: wr_target <= TGT_OFFSET;
                    MODE_GAIN:   wr_target <= TGT_GAIN;
                    default:     wr_target <= TGT_NONE;
                endcase
            end
        end
    end

    // per-channel register arrays take the write event
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                in_a_q[i] <= CH_RST;
                in_b_q[i] <= CH_RST;
                off_q[i]  <= CH_RST;
                gain_q[i] <= CH_RST;
            end
        end
        else if (wr_valid)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (wr_mask[i])
                begin
                    if (wr_target == TGT_IN_A)
                        in_a_q[i] <= wr_value;
                    if (wr_target == TGT_IN_B)
                        in_b_q[i] <= wr_value;
                    if (wr_target == TGT_OFFSET)
                        off_q[i] <= wr_value;
                    if (wr_target == TGT_GAIN)
                        gain_q[i] <= wr_value;
                end
            end
        end
    end

    // special function registers; other codes leave them alone
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_q <= CTRL_RST;
            ofs_q[0] <= OFS_RST;
            ofs_q[1] <= OFS_RST;
            ofs_q[2] <= OFS_RST;
            bsel_q <= {NUM_GROUPS{BSEL_RST}};
        end
        else if (spec_wr)
        begin
            if (code == FN_CTRL)
                ctrl_q <= arg[2:0];
            if (code == FN_OFFSET_DAC_VALUE_0)
                ofs_q[0] <= arg[VAL_W-1:0];
            if (code == FN_OFFSET_DAC_VALUE_1)
                ofs_q[1] <= arg[VAL_W-1:0];
            if (code == FN_OFFSET_DAC_VALUE_2)
                ofs_q[2] <= arg[VAL_W-1:0];
            for (int k = 0; k < NUM_GROUPS; k++)
            begin
                if (int'(code) == int'(FN_BSEL0) + k || code == FN_BSEL_ALL)
                    bsel_q[k*GROUP_CH +: GROUP_CH] <= arg[7:0];
            end
        end
    end

    // readback value mux; upper byte of the output word is zero
    always_comb
    begin
        logic [5:0] sel;
        logic [5:0] ch;
        sel    = rb_sel_q[12:7];
        ch     = sel - RB_CH_BASE;
        rb_val = '0;
        if (rb_sel_q[15:13] == RB_SPECIAL)
        begin
            if (sel == RB_CTRL)
                rb_val = {11'h000, ot_s2_q, 1'b0, ctrl_q};
            else if (sel == RB_OFFSET_DAC_VALUE_0)
                rb_val = {2'h0, ofs_q[0]};
            else if (sel == RB_OFFSET_DAC_VALUE_1)
                rb_val = {2'h0, ofs_q[1]};
            else if (sel == RB_OFFSET_DAC_VALUE_2)
                rb_val = {2'h0, ofs_q[2]};
            else if (sel >= RB_BSEL0 && sel <= RB_BSEL4)
                rb_val = {8'h00, bsel_q[(int'(sel) - int'(RB_BSEL0))*GROUP_CH +: GROUP_CH]};
        end
        else if (sel >= RB_CH_BASE && sel <= RB_CH_LAST && int'(ch) < NUM_CH)
        begin
            unique case (rb_sel_q[15:13])
                RB_IN_A:   rb_val = {2'h0, in_a_q[ch]};
                RB_IN_B:   rb_val = {2'h0, in_b_q[ch]};
                RB_OFFSET: rb_val = {2'h0, off_q[ch]};
                RB_GAIN:   rb_val = {2'h0, gain_q[ch]};
                default:   rb_val = '0;
            endcase
        end
    end

    // readback selection and sdo drive window; a new selection wins over the end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rb_sel_q    <= '0;
            rb_pend_q   <= 1'b0;
            rb_active_q <= 1'b0;
            oe_q        <= 1'b0;
        end
        else
        begin
            if (frame_start && rb_pend_q)
            begin
                rb_pend_q   <= 1'b0;
                rb_active_q <= 1'b1;
            end
            if (frame_end && rb_active_q)
            begin
                rb_active_q <= 1'b0;
                oe_q        <= 1'b0;
            end
            if (spec_wr && code == FN_RBSEL)
            begin
                rb_sel_q  <= arg;
                rb_pend_q <= 1'b1;
                oe_q      <= 1'b1;
            end
        end
    end

    // output shifter, msb first, advanced on each falling link clock edge of the readback frame
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            out_sr_q <= '0;
        else if (frame_start && rb_pend_q)
            out_sr_q <= {8'h00, rb_val};
        else if (rb_active_q && sclk_fall)
            out_sr_q <= {out_sr_q[WORD_BITS-2:0], 1'b0};
    end

    // register outputs
    assign sdo                 = out_sr_q[WORD_BITS-1];
    assign sdo_oe              = oe_q;
    assign power_down_req      = ctrl_q[CTRL_PD_BIT];
    assign thermal_shutdown_en = ctrl_q[CTRL_TSD_BIT];
    assign input_bank_bit      = ctrl_q[CTRL_BANK_BIT];
    assign overtemp_flag       = ot_s2_q;
    assign offset_dac_value_0  = ofs_q[0];
    assign offset_dac_value_1  = ofs_q[1];
    assign offset_dac_value_2  = ofs_q[2];
    assign bank_select         = bsel_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    frame_len_a: assert property (wr_valid |-> $past(cnt_q) == CNT_FULL)
        else $error("write without a full frame");
    ofs_load_a: assert property (spec_wr && code == FN_OFFSET_DAC_VALUE_1
        |=> offset_dac_value_1 == $past(arg[VAL_W-1:0]))
        else $error("offset dac 1 not loaded");
    bsel_all_a: assert property (spec_wr && code == FN_BSEL_ALL
        |=> bank_select == {NUM_GROUPS{$past(arg[7:0])}})
        else $error("block bank-select write wrong");
    ctrl_write_a: assert property (spec_wr && code == FN_CTRL
        |=> {input_bank_bit, thermal_shutdown_en, power_down_req} == $past(arg[2:0]))
        else $error("control write wrong");
    bank_route_a: assert property (data_wr && mode == MODE_INPUT && input_bank_bit
        |=> wr_valid && wr_target == TGT_IN_B)
        else $error("input write not routed to bank b");
    grp_skip_a: assert property (data_wr && word_q[ADDR_HI:ADDR_HI-2] == 3'h7
        |=> wr_mask[GROUP_CH-1:0] == '0 && $countones(wr_mask) == NUM_GROUPS - 1)
        else $error("group 0 touched");
    single_ch_a: assert property (data_wr && word_q[ADDR_HI:ADDR_HI-2] == 3'h2
        |=> $onehot(wr_mask) && wr_mask[GROUP_CH + int'($past(word_q[18:16]))])
        else $error("single channel mask wrong");
    reserved_addr_a: assert property (data_wr && word_q[ADDR_HI:ADDR_HI-2] == 3'h0
        && word_q[18:17] == 2'h3 |=> wr_mask == '0)
        else $error("reserved address wrote channels");
    nop_stable_a: assert property (spec_wr && code == FN_NOP
        |=> $stable(ctrl_q) && $stable(bank_select) && $stable(offset_dac_value_0))
        else $error("no-operation changed state");
    rb_latch_a: assert property (spec_wr && code == FN_RBSEL
        |=> rb_pend_q && sdo_oe && rb_sel_q == $past(arg))
        else $error("readback selection not latched");

    data_cov: cover property (wr_valid && wr_target == TGT_GAIN);
    read_cov: cover property (frame_start && rb_pend_q);
    abort_cov: cover property (frame_end && cnt_q < CNT_FULL);

endmodule

// ---- testbench/dcd_host.sv ----
`timescale 1ns/10ps
// host side of the serial link: frames words, clocks them out, captures readback
module dcd_host
(
    // pacing clock
    input  wire logic        clk,
    // serial link pins
    output logic             sync_n,
    output logic             sclk,
    output logic             sdi,
    input  wire logic        sdo
);
    logic [23:0] rb;

    // idle: frame high, link clock low
    initial
    begin
        sync_n = 1'h1;
        sclk   = 1'h0;
        sdi    = 1'h0;
        rb     = 24'h000000;
    end

    // one frame of nb bits, msb first, 80 ns link clock
    task automatic send(input logic [23:0] w, input int nb);
        logic [23:0] s;
        int          i;
        s = w;
        if (w[23:22] != 2'h0)
            s[1:0] = 2'h0;
        @(posedge clk);
        #1 sync_n = 1'h0;
        repeat (4) @(posedge clk);
        for (i = 0; i < nb; i++)
        begin
            #1 sdi = (i < 24) ? s[23-i] : ~sdi;
            sclk = 1'h1;
            rb   = {rb[22:0], sdo};  // readback taken on the rising link edge
            repeat (4) @(posedge clk);
            #1 sclk = 1'h0;
            repeat (4) @(posedge clk);
        end
        #1 sync_n = 1'h1;
        sdi = ~sdi;  // released data line does not hold the last bit
        repeat (8) @(posedge clk);
    endtask
endmodule

// ---- testbench/tb_dcd_decoder.sv ----
`timescale 1ns/10ps
module tb_dcd_decoder;
    import dcd_pkg::*;
    logic              clk;
    logic              rst_n;
    logic              sync_n;
    logic              sclk;
    logic              sdi;
    logic              sdo;
    logic              sdo_oe;
    logic              overtemp_in;
    logic              power_down_req;
    logic              thermal_shutdown_en;
    logic              input_bank_bit;
    logic              overtemp_flag;
    logic [13:0]       offset_dac_value_0;
    logic [13:0]       offset_dac_value_1;
    logic [13:0]       offset_dac_value_2;
    logic [39:0]       bank_select;
    logic              wr_valid;
    dcd_target_t       wr_target;
    logic [39:0]       wr_mask;
    logic [13:0]       wr_value;
    int                errors;
    int                checks;
    int                pulses;
    int                seed;
    int                i;
    logic [31:0]       r;
    // expected register state
    logic [2:0]        e_ctrl;
    logic              e_ot;
    logic [13:0]       e_ofs [3];
    logic [39:0]       e_bsel;
    logic [13:0]       e_ch [4][40];
    logic [15:0]       e_rb;

    dcd_decoder dut (.clk, .rst_n, .sync_n, .sclk, .sdi, .sdo, .sdo_oe, .overtemp_in,
        .power_down_req, .thermal_shutdown_en, .input_bank_bit, .overtemp_flag,
        .offset_dac_value_0, .offset_dac_value_1, .offset_dac_value_2, .bank_select,
        .wr_valid, .wr_target, .wr_mask, .wr_value);
    dcd_host host (.clk, .sync_n, .sclk, .sdi, .sdo);

    // 100 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // count channel write events
    always @(posedge clk)
        if (wr_valid === 1'h1)
            pulses <= pulses + 1;

    // hang guard
    initial
    begin
        repeat (60000) @(posedge clk);
        errors++;
        print_verdict();
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // channels hit by a data-mode address
    function automatic logic [39:0] exp_mask(input logic [5:0] a);
        int g;
        exp_mask = 40'h0;
        if (a[5:3] == 3'h0)
        begin
            if (a[2:0] == 3'h0)
                exp_mask = 40'hff_ffff_ffff;
            else if (a[2:0] <= 3'h5)
                exp_mask[8*(a[2:0]-1) +: 8] = 8'hff;
        end
        else if (a[5:3] <= 3'h5)
            exp_mask[8*(a[5:3]-1) + a[2:0]] = 1'h1;
        else
            for (g = (a[5:3] == 3'h6) ? 0 : 1; g < 5; g++)
                exp_mask[8*g + a[2:0]] = 1'h1;
    endfunction

    // value that a readback selection should return
    function automatic logic [15:0] rb_value(input logic [15:0] a);
        logic [5:0] c;
        c = a[12:7];
        rb_value = 16'h0000;
        if (a[15:13] < 3'h4 && c >= RB_CH_BASE && c <= RB_CH_LAST)
            rb_value = {2'h0, e_ch[a[15:13]][c-8]};
        else if (a[15:13] == RB_SPECIAL && c == RB_CTRL)
            rb_value = {11'h0, e_ot, 1'h0, e_ctrl};
        else if (a[15:13] == RB_SPECIAL && c >= RB_OFFSET_DAC_VALUE_0 && c <= RB_OFFSET_DAC_VALUE_2)
            rb_value = {2'h0, e_ofs[c-2]};
        else if (a[15:13] == RB_SPECIAL && c >= RB_BSEL0 && c <= RB_BSEL4)
            rb_value = {8'h00, e_bsel[8*(c-6) +: 8]};
    endfunction

    task automatic check_regs();
        chk(power_down_req, e_ctrl[0], "power down");
        chk(thermal_shutdown_en, e_ctrl[1], "thermal");
        chk(input_bank_bit, e_ctrl[2], "input bank");
        chk(overtemp_flag, e_ot, "overtemp");
        chk(offset_dac_value_0, e_ofs[0], "offset 0");
        chk(offset_dac_value_1, e_ofs[1], "offset 1");
        chk(offset_dac_value_2, e_ofs[2], "offset 2");
        chk(bank_select, e_bsel, "bank select");
    endtask

    // send one frame, update the expected state, compare the register outputs and any write event
    task automatic frame(input logic [23:0] w, input int nb);
        int          p0;
        int          k;
        logic [5:0]  fc;
        logic [15:0] a;
        logic [39:0] m;
        dcd_target_t t;
        p0 = pulses;
        fc = w[21:16];
        a  = w[15:0];
        m  = exp_mask(w[21:16]);
        host.send(w, nb);
        if (nb != 24)
            chk(pulses - p0, 0, "cut frame");
        else if (w[23:22] != MODE_SPECIAL)
        begin
            t = (w[23:22] == MODE_INPUT) ? (e_ctrl[2] ? TGT_IN_B : TGT_IN_A) :
                (w[23:22] == MODE_OFFSET) ? TGT_OFFSET : TGT_GAIN;
            chk(pulses - p0, 1, "write event");
            chk(wr_target, t, "target");
            chk(wr_mask, m, "mask");
            chk(wr_value, w[15:2], "value");
            for (k = 0; k < 40; k++)
                if (m[k])
                    e_ch[t-1][k] = w[15:2];
        end
        else
        begin
            chk(pulses - p0, 0, "special event");
            if (fc == FN_CTRL)
                e_ctrl = a[2:0];
            else if (fc >= FN_OFFSET_DAC_VALUE_0 && fc <= FN_OFFSET_DAC_VALUE_2)
                e_ofs[fc-2] = a[13:0];
            else if (fc == FN_RBSEL)
                e_rb = rb_value(a);
            else if (fc >= FN_BSEL0 && fc <= FN_BSEL4)
                e_bsel[8*(fc-6) +: 8] = a[7:0];
            else if (fc == FN_BSEL_ALL)
                e_bsel = {5{a[7:0]}};
        end
        check_regs();
    endtask

    // select a register, then shift it out with a no-operation frame
    task automatic readback(input logic [15:0] a);
        frame({8'h05, a}, 24);
        chk(sdo_oe, 1'h1, "sdo driven");
        frame(24'h000000, 24);
        chk(host.rb, {8'h00, e_rb}, "readback");
        chk(sdo_oe, 1'h0, "sdo released");
    endtask

    // main sequence
    initial
    begin
        seed = 32'h21ac;
        errors = 0;
        checks = 0;
        pulses = 0;
        rst_n = 1'h0;
        overtemp_in = 1'h0;
        e_ctrl = 3'h0;
        e_ot = 1'h0;
        e_bsel = 40'h0;
        e_rb = 16'h0000;
        foreach (e_ofs[k])
            e_ofs[k] = 14'h0000;
        foreach (e_ch[a, b])
            e_ch[a][b] = 14'h0000;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'h1;
        repeat (4) @(posedge clk);
        check_regs();
        chk(sdo_oe, 1'h0, "sdo idle");
        // every address once, data modes taken in turn, input bank flipped midway
        for (i = 0; i < 64; i++)
        begin
            r = $random(seed);
            if (i == 32)
                frame(24'h010004, 24);
            if (i == 48)
                frame(24'h010000, 24);
            frame({2'(1 + i % 3), 6'(i), r[13:0], 2'h0}, 24);
        end
        // all control combinations; bits 4:3 sent as zero, bits 15:5 random
        for (i = 0; i < 8; i++)
        begin
            r = $random(seed);
            frame({8'h01, r[15:5], 2'h0, 3'(i)}, 24);
        end
        // bank-select block writes, then single bank-select and offset codes
        frame({8'h0b, 16'h00ff}, 24);
        frame({8'h0b, 16'hff00}, 24);
        for (i = 11; i >= 2; i--)
        begin
            r = $random(seed);
            if (i != 5)
                frame({2'h0, 6'(i), r[15:0]}, 24);
        end
        // no-operation and reserved codes change nothing
        frame(24'h000000, 24);
        for (i = 0; i < 3; i++)
        begin
            r = $random(seed);
            frame({2'h0, 6'(12 + i * 20), r[15:0]}, 24);
        end
        // aborted and overlong frames are dropped
        frame(24'hc0abcd, 23);
        frame(24'hc0abcd, 25);
        frame(24'h010007, 23);
        // overtemperature is read-only
        @(posedge clk);
        #1 overtemp_in = 1'h1;
        e_ot = 1'h1;
        repeat (5) @(posedge clk);
        frame(24'h010000, 24);
        // readback of special registers, random channels and invalid picks
        for (i = 1; i < 11; i++)
        begin
            r = $random(seed);
            readback({3'h4, 6'(i), r[6:0]});
        end
        for (i = 0; i < 12; i++)
        begin
            r = $random(seed);
            readback({1'h0, r[1:0], 6'(8 + r[31:16] % 40), r[8:2]});
        end
        readback(16'h1800);
        readback({3'h7, 6'h08, 7'h00});
        print_verdict();
    end
endmodule
